//--- rtl/fipr_pkg.sv
// Shared constants for the idle, polling and result status block
package fipr_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 50;
  localparam int POLL_TIME_NS = 1000000;    // 1 msec at 500 Kbps
  localparam int PDOWN_TIME_NS = 512000000; // 512 msec at 500 Kbps
  localparam int POLL_CYCLES = POLL_TIME_NS / MCLK_PERIOD_NS;
  localparam int PDOWN_CYCLES = PDOWN_TIME_NS / MCLK_PERIOD_NS;
  localparam int NUM_DRIVES = 4;
  localparam logic [2:0] STEP_LEN = 3'h4;

  // ---------------------------------------------------------------
  // Data rate select and timer weights in tenths of the 500 Kbps rate
  // ---------------------------------------------------------------
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [4:0] WEIGHT_500K = 5'h0A;
  localparam logic [4:0] WEIGHT_300K = 5'h06;
  localparam logic [4:0] WEIGHT_250K = 5'h05;
  localparam logic [4:0] WEIGHT_1M = 5'h14;
  localparam int WEIGHT_UNIT = 10;

  // ---------------------------------------------------------------
  // Host port offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_MAIN_STATUS = 3'h4;
  localparam logic [2:0] OFS_DATA_PORT = 3'h5;

  // ---------------------------------------------------------------
  // Main status register bits
  // ---------------------------------------------------------------
  localparam int MSR_RQM_BIT = 7;
  localparam int MSR_DIO_BIT = 6;
  localparam int MSR_BUSY_BIT = 4;

  // ---------------------------------------------------------------
  // Interrupt reason codes of status byte 0
  // ---------------------------------------------------------------
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_INVALID = 2'h2;
  localparam logic [1:0] IC_READY_CHG = 2'h3;
  localparam logic [1:0] RESULT_LEN_MAX = 2'h3;

  // ---------------------------------------------------------------
  // Controller phases
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_POLL = 5'h02,
    PH_CMD = 5'h04,
    PH_EXEC = 5'h08,
    PH_RESULT = 5'h10
  } fipr_phase_e;
endpackage : fipr_pkg

//--- rtl/fipr_rate_timer.sv
// Rate-scaled interval timer, one tick per scaled period
`timescale 1ns/10ps
`default_nettype none
module fipr_rate_timer #(
  parameter int LIMIT = 20000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] rateSel,
  output logic tick
);
  // ---------------------------------------------------------------
  // Weighted accumulator
  // ---------------------------------------------------------------
  // Fractional weights avoid a divider per rate
  localparam logic [31:0] TARGET = 32'(LIMIT * fipr_pkg::WEIGHT_UNIT);
  logic [31:0] acc_ff;
  logic [31:0] nxt_acc;
  logic [4:0] weight;
  logic reached;

  assign weight = (rateSel == fipr_pkg::RATE_1M) ? fipr_pkg::WEIGHT_1M :
                  (rateSel == fipr_pkg::RATE_300K) ? fipr_pkg::WEIGHT_300K :
                  (rateSel == fipr_pkg::RATE_250K) ? fipr_pkg::WEIGHT_250K :
                  fipr_pkg::WEIGHT_500K;
  assign nxt_acc = acc_ff + {27'h0, weight};
  assign reached = run && (nxt_acc >= TARGET);
  assign tick = reached;

  always_ff @(posedge mclk) begin
    if (rst || !run || reached) begin
      acc_ff <= 32'h0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end
endmodule : fipr_rate_timer
`default_nettype wire

//--- rtl/fipr_status_fmt.sv
// Packs execution outcome flags into the three result status bytes
`timescale 1ns/10ps
`default_nettype none
module fipr_status_fmt (
  input wire logic [1:0] intReason,
  input wire logic [1:0] driveSel,
  input wire logic headSide,
  input wire logic equipCheck,
  input wire logic seekEnd,
  input wire logic missAddrMark,
  input wire logic writeProtHit,
  input wire logic missingData,
  input wire logic overUnderRun,
  input wire logic crcError,
  input wire logic endOfTrack,
  input wire logic dataMarkMissing,
  input wire logic badTrack,
  input wire logic scanNotSat,
  output logic [7:0] status0,
  output logic [7:0] status1,
  output logic [7:0] status2
);
  // ---------------------------------------------------------------
  // Byte layout
  // ---------------------------------------------------------------
  assign status0 = {intReason, seekEnd, equipCheck, 1'b0, headSide, driveSel};
  assign status1 = {endOfTrack, 1'b0, crcError, overUnderRun, 1'b0, missingData,
                    writeProtHit, missAddrMark};
  // Upper five bits of byte 2 are tied to zero here and read zero
  assign status2 = {5'h00, scanNotSat, badTrack, missAddrMark & dataMarkMissing};
endmodule : fipr_status_fmt
`default_nettype wire

//--- rtl/fipr_ctrl.sv
// Floppy controller idle, drive polling and result status phase control
//
// What this block does
// - Idle after resets: request set, direction clear
// - Opcode enters command phase; completion returns idle
// - Idle polls four drives every scaled millisecond
// - Ready change after reset interrupts for all four drives
// - Polling pass always does stepping and power-down
// - Auto power-down waits scaled 512 ms
// - Opcode during poll holds request until done
// - Result bytes at data port; status always readable
// - Byte 0 low bits: drive, head, zero
// - Byte 0 bit 4: track zero not reached
// - Byte 0 bit 5: seek command completed
// - Byte 0 top bits give interrupt reason
// - Missing address mark and its location
// - Byte 1 bit 1: write protected target
// - Byte 1 bit 2: missing data cases
// - Byte 1 bit 4: overrun or underrun
// - Byte 1 bit 5 CRC; bits 3,6 zero
// - Byte 1 bit 7: end of track
// - Byte 2 bit 1: bad track
// - Byte 2 bit 2: scan not satisfied
`timescale 1ns/10ps
`default_nettype none
module fipr_ctrl #(
  parameter int POLL_CYCLES = fipr_pkg::POLL_CYCLES,
  parameter int PDOWN_CYCLES = fipr_pkg::PDOWN_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic softReset,
  // Host port
  input wire logic [2:0] hostAddr,
  input wire logic hostRd,
  input wire logic hostWr,
  input wire logic [7:0] hostWrData,
  output logic [7:0] hostRdData,
  output logic intReq,
  // Command engine side
  output logic opcodeValid,
  output logic paramValid,
  output logic [7:0] cmdByte,
  input wire logic cmdBytesDone,
  input wire logic cmdDone,
  input wire logic [1:0] resultLen,
  input wire logic senseIntCmd,
  input wire logic [1:0] intReason,
  input wire logic [1:0] driveSel,
  input wire logic headSide,
  input wire logic seekEnd,
  input wire logic missAddrMark,
  input wire logic writeProtHit,
  input wire logic missingData,
  input wire logic overUnderRun,
  input wire logic crcError,
  input wire logic endOfTrack,
  input wire logic dataMarkMissing,
  input wire logic badTrack,
  input wire logic scanNotSat,
  input wire logic [1:0] rateSel,
  input wire logic pollDisable,
  input wire logic autoPowerDown,
  input wire logic motorOffExpired,
  input wire logic [3:0] stepPending,
  input wire logic [3:0] stepDirIn,
  output logic stepAck,
  // Drive pins
  input wire logic trackZeroInputN,
  output logic stepOut,
  output logic dirOut,
  output logic [1:0] stepDrive,
  output logic powerDown
);
  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  logic trk0Meta_ff;
  logic trk0Sync_ff;

  always_ff @(posedge mclk) begin
    trk0Meta_ff <= trackZeroInputN;
    trk0Sync_ff <= trk0Meta_ff;
  end

  // ---------------------------------------------------------------
  // Phase machine state
  // ---------------------------------------------------------------
  fipr_pkg::fipr_phase_e phase_ff;
  fipr_pkg::fipr_phase_e nxt_phase;
  logic anyReset;
  logic dataWr;
  logic dataRd;
  logic pollTick;
  logic pollDone;
  logic lastResult;
  logic holdParam_ff;
  logic [1:0] pollIdx_ff;
  logic [1:0] resIdx_ff;
  logic [1:0] resLen_ff;
  logic [2:0] stepCnt_ff;
  logic [7:0] cmdByte_ff;
  logic [7:0] st0_ff;
  logic [7:0] st1_ff;
  logic [7:0] st2_ff;
  logic [7:0] fmt0;
  logic [7:0] fmt1;
  logic [7:0] fmt2;
  logic [3:0] readyChg_ff;
  logic armChg_ff;
  logic intReq_ff;
  logic trk0Seen_ff;
  logic pdRun;
  logic pdTick;
  logic pdown_ff;
  logic stepOut_ff;
  logic dirOut_ff;
  logic [1:0] stepDrive_ff;
  logic [7:0] rdData_ff;
  logic [7:0] mainStatus;
  logic [7:0] resultByte;
  logic [1:0] chgDrive;
  logic chgAny;
  logic senseChg;
  logic stepNow;

  assign anyReset = rst || softReset;
  assign dataWr = hostWr && (hostAddr == fipr_pkg::OFS_DATA_PORT);
  assign dataRd = hostRd && (hostAddr == fipr_pkg::OFS_DATA_PORT);
  assign pollDone = (phase_ff == fipr_pkg::PH_POLL) && (pollIdx_ff == 2'h3)
                    && (stepCnt_ff == 3'h0);
  assign lastResult = dataRd && (resIdx_ff == resLen_ff - 2'h1);

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  // Poll timer only counts in idle, so command traffic restarts the interval
  fipr_rate_timer #(
    .LIMIT(POLL_CYCLES)
  ) u_poll_timer (
    .mclk(mclk),
    .rst(anyReset),
    .run(phase_ff == fipr_pkg::PH_IDLE),
    .rateSel(rateSel),
    .tick(pollTick)
  );

  assign pdRun = autoPowerDown && motorOffExpired && !pdown_ff
                 && (phase_ff == fipr_pkg::PH_IDLE || phase_ff == fipr_pkg::PH_POLL);

  fipr_rate_timer #(
    .LIMIT(PDOWN_CYCLES)
  ) u_pdown_timer (
    .mclk(mclk),
    .rst(anyReset),
    .run(pdRun),
    .rateSel(rateSel),
    .tick(pdTick)
  );

  // ---------------------------------------------------------------
  // Next phase
  // ---------------------------------------------------------------
  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      fipr_pkg::PH_IDLE: begin
        if (dataWr) begin
          nxt_phase = fipr_pkg::PH_CMD;
        end else if (pollTick) begin
          nxt_phase = fipr_pkg::PH_POLL;
        end
      end
      fipr_pkg::PH_POLL: begin
        if (pollDone) begin
          nxt_phase = holdParam_ff ? fipr_pkg::PH_CMD : fipr_pkg::PH_IDLE;
        end
      end
      fipr_pkg::PH_CMD: begin
        if (cmdBytesDone) begin
          nxt_phase = fipr_pkg::PH_EXEC;
        end
      end
      fipr_pkg::PH_EXEC: begin
        if (cmdDone) begin
          nxt_phase = (resultLen == 2'h0) ? fipr_pkg::PH_IDLE : fipr_pkg::PH_RESULT;
        end
      end
      fipr_pkg::PH_RESULT: begin
        if (lastResult) begin
          nxt_phase = fipr_pkg::PH_IDLE;
        end
      end
      default: begin
        nxt_phase = fipr_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (anyReset) begin
      phase_ff <= fipr_pkg::PH_IDLE;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // ---------------------------------------------------------------
  // Command byte capture
  // ---------------------------------------------------------------
  // Opcode seen mid-poll is parked until the pass finishes
  always_ff @(posedge mclk) begin
    if (anyReset) begin
      holdParam_ff <= 1'b0;
      cmdByte_ff <= 8'h00;
    end else begin
      if (phase_ff == fipr_pkg::PH_POLL && dataWr) begin
        holdParam_ff <= 1'b1;
      end else if (pollDone) begin
        holdParam_ff <= 1'b0;
      end
      if (dataWr) begin
        cmdByte_ff <= hostWrData;
      end
    end
  end

  assign opcodeValid = dataWr && (phase_ff == fipr_pkg::PH_IDLE
                                  || (phase_ff == fipr_pkg::PH_POLL && !holdParam_ff));
  assign paramValid = dataWr && (phase_ff == fipr_pkg::PH_CMD);
  assign cmdByte = cmdByte_ff;

  // ---------------------------------------------------------------
  // Polling pass: drive scan and stepping
  // ---------------------------------------------------------------
  // One drive per visit; a step pulse stretches that visit, except on drive 3, where the pass ends in the step's first cycle
  assign stepNow = (phase_ff == fipr_pkg::PH_POLL) && (stepCnt_ff == 3'h0)
                   && stepPending[pollIdx_ff] && !stepOut_ff;

  always_ff @(posedge mclk) begin
    if (anyReset || phase_ff != fipr_pkg::PH_POLL) begin
      pollIdx_ff <= 2'h0;
      stepCnt_ff <= 3'h0;
      stepOut_ff <= 1'b0;
    end else if (stepNow) begin
      stepCnt_ff <= fipr_pkg::STEP_LEN;
      stepOut_ff <= 1'b1;
    end else if (stepCnt_ff != 3'h0) begin
      stepCnt_ff <= stepCnt_ff - 3'h1;
      stepOut_ff <= (stepCnt_ff != 3'h1);
    end else if (pollIdx_ff != 2'h3) begin
      pollIdx_ff <= pollIdx_ff + 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (anyReset) begin
      dirOut_ff <= 1'b0;
      stepDrive_ff <= 2'h0;
    end else if (stepNow) begin
      dirOut_ff <= stepDirIn[pollIdx_ff];
      stepDrive_ff <= pollIdx_ff;
    end
  end

  assign stepAck = stepNow;
  assign stepOut = stepOut_ff;
  assign dirOut = dirOut_ff;
  assign stepDrive = stepDrive_ff;

  // ---------------------------------------------------------------
  // Ready change flags
  // ---------------------------------------------------------------
  // Armed by reset only; the first polling pass raises all four
  assign chgAny = |readyChg_ff;
  assign chgDrive = readyChg_ff[0] ? 2'h0 : readyChg_ff[1] ? 2'h1 :
                    readyChg_ff[2] ? 2'h2 : 2'h3;
  assign senseChg = cmdDone && senseIntCmd && chgAny;

  genvar d;
  generate
    for (d = 0; d < fipr_pkg::NUM_DRIVES; d++) begin : g_chg
      always_ff @(posedge mclk) begin
        if (anyReset) begin
          readyChg_ff[d] <= 1'b0;
        end else if (armChg_ff && !pollDisable && pollDone) begin
          readyChg_ff[d] <= 1'b1;
        end else if (senseChg && chgDrive == 2'(d)) begin
          readyChg_ff[d] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (anyReset) begin
      armChg_ff <= 1'b1;
      intReq_ff <= 1'b0;
    end else begin
      if (pollDone) begin
        armChg_ff <= 1'b0;
      end
      if (armChg_ff && !pollDisable && pollDone) begin
        intReq_ff <= 1'b1;
      end else if (phase_ff == fipr_pkg::PH_EXEC && cmdDone && resultLen != 2'h0) begin
        intReq_ff <= 1'b1;
      end else if (dataRd || dataWr) begin
        intReq_ff <= 1'b0;
      end
    end
  end

  assign intReq = intReq_ff;

  // ---------------------------------------------------------------
  // Track zero seen during execution
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (anyReset || opcodeValid) begin
      trk0Seen_ff <= 1'b0;
    end else if (phase_ff == fipr_pkg::PH_EXEC && !trk0Sync_ff) begin
      trk0Seen_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Result bytes
  // ---------------------------------------------------------------
  fipr_status_fmt u_fmt (
    .intReason(senseChg ? fipr_pkg::IC_READY_CHG : intReason),
    .driveSel(senseChg ? chgDrive : driveSel),
    .headSide(senseChg ? 1'b0 : headSide),
    .equipCheck(!senseChg && seekEnd && !trk0Seen_ff),
    .seekEnd(!senseChg && seekEnd),
    .missAddrMark(missAddrMark),
    .writeProtHit(writeProtHit),
    .missingData(missingData),
    .overUnderRun(overUnderRun),
    .crcError(crcError),
    .endOfTrack(endOfTrack),
    .dataMarkMissing(dataMarkMissing),
    .badTrack(badTrack),
    .scanNotSat(scanNotSat),
    .status0(fmt0),
    .status1(fmt1),
    .status2(fmt2)
  );

  always_ff @(posedge mclk) begin
    if (anyReset) begin
      st0_ff <= 8'h00;
      st1_ff <= 8'h00;
      st2_ff <= 8'h00;
      resLen_ff <= 2'h0;
      resIdx_ff <= 2'h0;
    end else if (phase_ff == fipr_pkg::PH_EXEC && cmdDone) begin
      st0_ff <= fmt0;
      st1_ff <= fmt1;
      st2_ff <= fmt2;
      resLen_ff <= (resultLen > fipr_pkg::RESULT_LEN_MAX) ? fipr_pkg::RESULT_LEN_MAX : resultLen;
      resIdx_ff <= 2'h0;
    end else if (phase_ff == fipr_pkg::PH_RESULT && dataRd) begin
      resIdx_ff <= resIdx_ff + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Power-down
  // ---------------------------------------------------------------
  // Any host access counts as recovery; the controller then sits idle
  always_ff @(posedge mclk) begin
    if (anyReset || hostRd || hostWr) begin
      pdown_ff <= 1'b0;
    end else if (pdTick) begin
      pdown_ff <= 1'b1;
    end
  end

  assign powerDown = pdown_ff;

  // ---------------------------------------------------------------
  // Host read path
  // ---------------------------------------------------------------
  assign mainStatus[fipr_pkg::MSR_RQM_BIT] = (phase_ff == fipr_pkg::PH_IDLE)
                                             || (phase_ff == fipr_pkg::PH_CMD)
                                             || (phase_ff == fipr_pkg::PH_RESULT);
  assign mainStatus[fipr_pkg::MSR_DIO_BIT] = (phase_ff == fipr_pkg::PH_RESULT);
  assign mainStatus[5] = 1'b0;
  assign mainStatus[fipr_pkg::MSR_BUSY_BIT] = (phase_ff == fipr_pkg::PH_CMD)
                                              || (phase_ff == fipr_pkg::PH_EXEC)
                                              || (phase_ff == fipr_pkg::PH_RESULT)
                                              || holdParam_ff;
  assign mainStatus[3:0] = readyChg_ff;

  assign resultByte = (resIdx_ff == 2'h0) ? st0_ff :
                      (resIdx_ff == 2'h1) ? st1_ff : st2_ff;

  // Result bytes only leave the data port in the result phase
  always_ff @(posedge mclk) begin
    if (anyReset) begin
      rdData_ff <= 8'h00;
    end else if (hostRd && hostAddr == fipr_pkg::OFS_MAIN_STATUS) begin
      rdData_ff <= mainStatus;
    end else if (dataRd && phase_ff == fipr_pkg::PH_RESULT) begin
      rdData_ff <= resultByte;
    end else if (hostRd) begin
      rdData_ff <= 8'h00;
    end
  end

  assign hostRdData = rdData_ff;
endmodule : fipr_ctrl
`default_nettype wire

//--- sim/fipr_engine_model.sv
// Command engine stand-in that finishes commands promptly or slowly
`timescale 1ns/10ps
`default_nettype none
module fipr_engine_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic opcodeValid,
  input wire logic paramValid,
  input wire logic senseIntCmd,
  input wire logic slow,
  output logic cmdBytesDone,
  output logic cmdDone
);
  logic [1:0] stage_ff;
  logic [3:0] wait_ff;
  wire logic start = paramValid || (opcodeValid && senseIntCmd);
  // Queries lack a parameter; outlast any poll
  wire logic [3:0] delay = (slow || senseIntCmd) ? 4'hF : 4'h1;
  always_ff @(posedge mclk) begin
    cmdBytesDone <= 1'b0;
    cmdDone <= 1'b0;
    if (rst) begin
      stage_ff <= 2'h0;
      wait_ff <= 4'h0;
    end else if (stage_ff == 2'h0) begin
      if (start) begin
        stage_ff <= 2'h1;
        wait_ff <= delay;
      end
    end else if (wait_ff != 4'h0) begin
      wait_ff <= wait_ff - 4'h1;
    end else begin
      cmdBytesDone <= (stage_ff == 2'h1);
      cmdDone <= (stage_ff == 2'h2);
      stage_ff <= (stage_ff == 2'h1) ? 2'h2 : 2'h0;
      wait_ff <= delay;
    end
  end
endmodule : fipr_engine_model
`default_nettype wire

//--- sim/fipr_ctrl_checker.sv
// Port timing checks of the phase control block
`timescale 1ns/10ps
`default_nettype none
module fipr_ctrl_checker #(
  parameter int POLL_CYCLES = 40,
  parameter int PDOWN_CYCLES = 200
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic softReset,
  input wire logic [2:0] hostAddr,
  input wire logic hostRd,
  input wire logic hostWr,
  input wire logic [7:0] hostRdData,
  input wire logic intReq,
  input wire logic opcodeValid,
  input wire logic paramValid,
  input wire logic stepOut,
  input wire logic dirOut,
  input wire logic [1:0] stepDrive,
  input wire logic powerDown,
  input wire logic autoPowerDown,
  input wire logic motorOffExpired
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || softReset);
  // Fastest rate halves the wait, so that is the floor
  int runCnt_ff;
  always_ff @(posedge mclk) begin
    if (rst || softReset || !(autoPowerDown && motorOffExpired)) begin
      runCnt_ff <= 0;
    end else begin
      runCnt_ff <= runCnt_ff + 1;
    end
  end
  sequence step_pulse;
    stepOut [*4] ##1 !stepOut;
  endsequence
  sequence dp_access;
    intReq && (hostRd || hostWr) && hostAddr == 3'h5;
  endsequence
  chk_reset_quiet: assert property (disable iff (1'b0) (rst || softReset) |=>
    hostRdData == 8'h00 && !intReq && !stepOut && !powerDown) else $error("reset state");
  chk_idle_msr: assert property (($fell(rst) || $fell(softReset)) && hostRd
    && hostAddr == 3'h4 |=> hostRdData == 8'h80) else $error("idle status");
  chk_opcode_wr: assert property (opcodeValid |-> hostWr && hostAddr == 3'h5)
    else $error("opcode strobe");
  chk_param_wr: assert property (paramValid |-> hostWr && hostAddr == 3'h5
    && !opcodeValid) else $error("param strobe");
  chk_step_shape: assert property ($rose(stepOut) |-> step_pulse)
    else $error("step length");
  chk_step_steady: assert property (stepOut && $past(stepOut) |-> $stable(dirOut)
    && $stable(stepDrive)) else $error("step dir moved");
  chk_rd_hold: assert property (!hostRd |=> $stable(hostRdData))
    else $error("read data moved");
  chk_unmapped_rd: assert property (hostRd && hostAddr != 3'h4 && hostAddr != 3'h5
    |=> hostRdData == 8'h00) else $error("unmapped read");
  chk_int_clear: assert property (dp_access |=> !intReq)
    else $error("interrupt kept");
  chk_pdown_wait: assert property ($rose(powerDown) |-> runCnt_ff >= PDOWN_CYCLES / 2)
    else $error("early power down");
endmodule : fipr_ctrl_checker
bind fipr_ctrl fipr_ctrl_checker #(.POLL_CYCLES(POLL_CYCLES), .PDOWN_CYCLES(PDOWN_CYCLES)) chk (
  .mclk, .rst, .softReset, .hostAddr, .hostRd, .hostWr, .hostRdData, .intReq, .opcodeValid,
  .paramValid, .stepOut, .dirOut, .stepDrive, .powerDown, .autoPowerDown, .motorOffExpired);
`default_nettype wire

//--- sim/tb_floppy_idle_poll_result_status.sv
// Self-checking bench of the idle, polling and result status block
`timescale 1ns/10ps
`default_nettype none
module tb_floppy_idle_poll_result_status;
  localparam int PDOWN = 200;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic softReset = 1'b0;
  logic [2:0] hostAddr = 3'h0;
  logic hostRd = 1'b0;
  logic hostWr = 1'b0;
  logic [7:0] hostWrData = 8'h00;
  logic [1:0] resultLen = 2'h0;
  logic senseIntCmd = 1'b0;
  logic [14:0] outc = 15'h0000;
  logic [14:0] outNext;
  logic [1:0] rateSel = 2'h0;
  logic pollDisable = 1'b0;
  logic autoPowerDown = 1'b0;
  logic motorOffExpired = 1'b0;
  logic [3:0] stepPending = 4'h0;
  logic [3:0] stepDirIn = 4'h0;
  logic trackZeroInputN = 1'b1;
  logic slow = 1'b0;
  logic [7:0] hostRdData, cmdByte;
  logic [7:0] rd;
  logic [1:0] stepDrive;
  logic intReq, opcodeValid, paramValid, cmdBytesDone, cmdDone, stepAck, stepOut, dirOut, powerDown;
  logic stepPrev = 1'b0;
  logic [31:0] lfsr = 32'hF315;
  int n_errors = 0;
  int num_checks = 0;
  int nSteps = 0;
  int cnt;
  always #25 mclk = ~mclk;
  fipr_ctrl #(.POLL_CYCLES(40), .PDOWN_CYCLES(PDOWN)) uut (
    .mclk, .rst, .softReset, .hostAddr, .hostRd, .hostWr, .hostWrData, .hostRdData,
    .intReq, .opcodeValid, .paramValid, .cmdByte, .cmdBytesDone, .cmdDone, .resultLen,
    .senseIntCmd, .intReason(outc[1:0]), .driveSel(outc[3:2]), .headSide(outc[4]),
    .seekEnd(outc[5]), .missAddrMark(outc[6]), .writeProtHit(outc[7]),
    .missingData(outc[8]), .overUnderRun(outc[9]), .crcError(outc[10]),
    .endOfTrack(outc[11]), .dataMarkMissing(outc[12]), .badTrack(outc[13]),
    .scanNotSat(outc[14]), .rateSel, .pollDisable, .autoPowerDown, .motorOffExpired,
    .stepPending, .stepDirIn, .stepAck, .trackZeroInputN, .stepOut, .dirOut, .stepDrive,
    .powerDown);
  fipr_engine_model eng (.mclk, .rst(rst || softReset), .opcodeValid, .paramValid,
    .senseIntCmd, .slow, .cmdBytesDone, .cmdDone);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [23:0] exp_status(input logic [14:0] o, input logic trk);
    return {o[1:0], o[5], o[5] & trk, 1'b0, o[4], o[3:2],
      o[11], 1'b0, o[10], o[9], 1'b0, o[8], o[7], o[6],
      5'h00, o[14], o[13], o[6] & o[12]};
  endfunction : exp_status
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic host_rd(input logic [2:0] a);
    hostAddr <= a;
    hostRd <= 1'b1;
    @(posedge mclk);
    hostRd <= 1'b0;
    @(posedge mclk);
    rd = hostRdData;
  endtask : host_rd
  task automatic host_wr(input logic [2:0] a, input logic [7:0] d);
    hostAddr <= a;
    hostWrData <= d;
    hostWr <= 1'b1;
    @(posedge mclk);
    hostWr <= 1'b0;
    @(posedge mclk);
  endtask : host_wr
  task automatic wait_msr(input logic [7:0] exp);
    host_rd(3'h4);
    for (int k = 0; k < 40 && rd !== exp; k++) begin
      host_rd(3'h4);
    end
    check("main status", rd, exp);
  endtask : wait_msr
  task automatic run_cmd(input logic [1:0] n, input logic [23:0] exp, input logic [3:0] low);
    resultLen <= n;
    host_wr(3'h5, lfsr[7:0]);
    if (senseIntCmd !== 1'b1) begin
      wait_msr({4'h9, low});
      host_wr(3'h5, lfsr[15:8]);
    end
    wait_msr({(n == 2'h0) ? 4'h8 : 4'hD, low});
    for (int k = 0; k < n; k++) begin
      host_rd(3'h5);
      check("result byte", rd, exp[23 - 8 * k -: 8]);
    end
    wait_msr({4'h8, low});
  endtask : run_cmd
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  always @(negedge mclk) begin
    if (stepOut === 1'b1 && !stepPrev) begin
      nSteps++;
      check("step direction", {7'h00, dirOut}, {7'h00, stepDirIn[stepDrive]});
    end
    stepPrev = stepOut;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    host_rd(3'h4);
    check("main status", rd, 8'h80);
    repeat (26) @(posedge mclk);
    check("intReq", {7'h00, intReq}, 8'h00);
    repeat (30) @(posedge mclk);
    check("intReq", {7'h00, intReq}, 8'h01);
    host_rd(3'h4);
    check("main status", rd, 8'h8F);
    senseIntCmd <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      run_cmd(2'h1, {6'h30, d[1:0], 16'h0000}, 4'hE << d);
    end
    $display("test poll and query done");
    senseIntCmd <= 1'b0;
    host_rd(3'h5);
    check("idle data read", rd, 8'h00);
    host_rd(3'h3);
    check("unmapped read", rd, 8'h00);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      outNext = {lfsr[14:2] | ((i == 0) ? 13'h0008 : 13'h0000), i[1:0]};
      outc <= outNext;
      trackZeroInputN <= (i != 0);
      slow <= lfsr[16];
      rateSel <= lfsr[18:17];
      stepDirIn <= lfsr[22:19];
      run_cmd(2'h3, exp_status(outNext, i != 0), 4'h0);
    end
    trackZeroInputN <= 1'b1;
    $display("test result status done");
    pollDisable <= 1'b1;
    rateSel <= 2'h0;
    resultLen <= 2'h0;
    stepPending <= 4'hF;
    for (int k = 0; k < 200 && stepAck !== 1'b1; k++) @(posedge mclk);
    host_wr(3'h5, 8'h0F);
    check("command byte", cmdByte, 8'h0F);
    host_rd(3'h4);
    check("request flag", {7'h00, rd[7]}, 8'h00);
    stepPending <= 4'h0;
    wait_msr(8'h90);
    host_wr(3'h5, 8'h00);
    wait_msr(8'h80);
    check("steps seen", {7'h00, nSteps != 0}, 8'h01);
    $display("test stepping done");
    autoPowerDown <= 1'b1;
    motorOffExpired <= 1'b1;
    for (cnt = 0; cnt < 400 && powerDown !== 1'b1; cnt++) @(posedge mclk);
    check("power down wait", {7'h00, cnt >= PDOWN && cnt <= PDOWN + 60}, 8'h01);
    host_rd(3'h4);
    check("powerDown", {7'h00, powerDown}, 8'h00);
    autoPowerDown <= 1'b0;
    $display("test power down done");
    softReset <= 1'b1;
    @(posedge mclk);
    softReset <= 1'b0;
    host_rd(3'h4);
    check("main status", rd, 8'h80);
    $display("test soft reset done");
    give_verdict();
  end
endmodule : tb_floppy_idle_poll_result_status
`default_nettype wire
